/* File: design/ext_irq_and_vector_select.v */
`timescale 1ns/1ps
`include "ext_irq_map.vh"
module ext_irq_and_vector_select #(
    parameter PIN_COUNT = 4,
    parameter ADDR_WIDTH = 16
) (
    input wire clock,
    input wire rst_b,
    input wire clk_en,
    input wire [7:0] reg_addr,
    input wire reg_data_space,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    input wire legacy_mode,
    input wire instr_done,
    input wire global_irq_enable,
    input wire [PIN_COUNT-1:0] ext_irq_mask_reg,
    input wire [PIN_COUNT-1:0] flag_clear_wr,
    input wire [PIN_COUNT-1:0] irq_entered,
    input wire [7:0] ext_irq_sense_high,
    input wire [PIN_COUNT-1:0] ext_irq_pins_all,
    input wire io_clk_running,
    input wire power_down,
    input wire wdt_tick,
    input wire startup_done,
    input wire app_section_lock,
    input wire boot_section_lock,
    input wire running_in_boot,
    input wire [ADDR_WIDTH-1:0] boot_start_addr,
    input wire [ADDR_WIDTH-1:0] vector_offset,
    output reg [ADDR_WIDTH-1:0] vector_addr,
    output wire vector_table_select,
    output reg [PIN_COUNT-1:0] ext_irq_pending_flag,
    output wire [PIN_COUNT-1:0] irq_request,
    output wire irq_blocked,
    output reg wake_request
);
    reg [7:0] ext_irq_sense_low;
    reg [5:0] core_control_spare;
    reg [1:0] wake_count;
    reg level_wake_armed;
    wire vector_change_unlock;
    wire change_block;
    wire [PIN_COUNT-1:0] level_low;
    wire [PIN_COUNT-1:0] edge_hit;
    wire hit_ctl;
    wire hit_sense;
    wire any_level;
    wire lock_block;

    // I/O addresses mirror into data space at plus 0x20
    function is_io_reg;
        input [7:0] addr;
        input data_space;
        input [7:0] io_offset;
        begin
            if (data_space) begin
                is_io_reg = (addr == io_offset + `IO_TO_DATA_OFFSET);
            end else begin
                is_io_reg = (addr == io_offset) && (addr <= `IO_SPACE_TOP);
            end
        end
    endfunction

    function [1:0] sense_of;
        input integer pin;
        input [7:0] low_reg;
        input [7:0] high_reg;
        begin
            if (pin < `LOWER_PIN_COUNT) begin
                sense_of = low_reg[pin*2 +: 2];
            end else begin
                sense_of = high_reg[(pin-`LOWER_PIN_COUNT)*2 +: 2];
            end
        end
    endfunction

    assign hit_ctl = is_io_reg(reg_addr, reg_data_space, `CORE_CONTROL_IO);
    // extended area only by data-space access; hidden in legacy mode
    assign hit_sense = reg_data_space && !legacy_mode &&
        (reg_addr == `EXT_IRQ_SENSE_LOW_DATA);

    vector_change_ctl u_vector_change_ctl (
        .clock(clock),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .ctl_wr(reg_wr && hit_ctl),
        .ctl_wdata(reg_wdata),
        .instr_done(instr_done),
        .vector_table_select(vector_table_select),
        .vector_change_unlock(vector_change_unlock),
        .change_block(change_block)
    );

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ext_irq_sense_low <= `EXT_IRQ_SENSE_LOW_RESET;
            core_control_spare <= 6'h00;
            reg_rdata <= 8'h00;
            vector_addr <= {ADDR_WIDTH{1'b0}};
        end else if (clk_en) begin
            if (reg_wr && hit_sense) begin
                ext_irq_sense_low <= reg_wdata;
            end
            if (reg_wr && hit_ctl) begin
                core_control_spare <= reg_wdata[7:2];
            end
            if (reg_rd) begin
                if (hit_ctl) begin
                    reg_rdata <= {core_control_spare, vector_table_select,
                        vector_change_unlock};
                end else if (hit_sense) begin
                    reg_rdata <= ext_irq_sense_low;
                end else begin
                    reg_rdata <= 8'h00;
                end
            end
            // table base is flash start or boot start
            if (vector_table_select) begin
                vector_addr <= boot_start_addr + vector_offset;
            end else begin
                vector_addr <= vector_offset;
            end
        end
    end

    genvar i;
    generate
        for (i = 0; i < PIN_COUNT; i = i + 1) begin : g_pin
            wire sample_en;
            wire [1:0] sense;
            assign sense = sense_of(i, ext_irq_sense_low, ext_irq_sense_high);
            // lower pins need no I/O clock; upper edges do
            assign sample_en = (i < `LOWER_PIN_COUNT) ? 1'b1 : io_clk_running;
            pin_sense u_pin_sense (
                .clock(clock),
                .rst_b(rst_b),
                .clk_en(clk_en),
                .sample_en(sample_en),
                .pin_raw(ext_irq_pins_all[i]),
                .sense(sense),
                .level_low(level_low[i]),
                .edge_hit(edge_hit[i])
            );
            always @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    ext_irq_pending_flag[i] <= 1'b0;
                end else if (clk_en) begin
                    if (sense == `SENSE_LOW_LEVEL) begin
                        ext_irq_pending_flag[i] <= 1'b0;
                    end else if (edge_hit[i]) begin
                        ext_irq_pending_flag[i] <= 1'b1;
                    end else if (flag_clear_wr[i] || irq_entered[i]) begin
                        ext_irq_pending_flag[i] <= 1'b0;
                    end
                end
            end
            // level requests while low, gated by enable and mask
            assign irq_request[i] = !irq_blocked && global_irq_enable &&
                ext_irq_mask_reg[i] && (level_low[i] || ext_irq_pending_flag[i]);
        end
    endgenerate

    // lock bits block the section that does not own the vectors
    assign lock_block = (vector_table_select && app_section_lock && !running_in_boot) ||
        (!vector_table_select && boot_section_lock && running_in_boot);
    // blocking never touches the global enable input
    assign irq_blocked = change_block || lock_block;

    assign any_level = |(level_low & ext_irq_mask_reg);

    // two watchdog samples of the level wake from power-down
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wake_count <= 2'd0;
            level_wake_armed <= 1'b0;
            wake_request <= 1'b0;
        end else if (clk_en) begin
            if (!power_down) begin
                wake_count <= 2'd0;
                level_wake_armed <= 1'b0;
                wake_request <= 1'b0;
            end else begin
                if (wdt_tick) begin
                    if (!any_level) begin
                        wake_count <= 2'd0;
                    end else if (wake_count != `WAKE_SAMPLES) begin
                        wake_count <= wake_count + 2'd1;
                    end
                end
                if (wake_count == `WAKE_SAMPLES) begin
                    level_wake_armed <= 1'b1;
                end
                // held until start-up end also wakes
                if (level_wake_armed || (|(edge_hit & ext_irq_mask_reg)) ||
                    (startup_done && any_level)) begin
                    wake_request <= 1'b1;
                end
            end
        end
    end
endmodule

/* File: design/ext_irq_map.vh */
// Behaviour
// - select bit places vector table: flash or boot.
// - block interrupts from unlock until after next instruction.
// - blocking leaves global interrupt enable untouched.
// - unlock clears after four cycles or select write.
// - boot lock bits block interrupts per running section.
// - pin activity triggers even when pin is output.
// - sense codes: low, reserved, falling, rising.
// - level mode requests continuously while pin low.
// - lower pins detected without the I/O clock.
// - upper pin edges need running I/O clock.
// - power-down level wake sampled twice on watchdog clock.
// - level gone before start-up end: wake, no request.
// - request needs global enable and mask bit.
// - sense fields: pin3 7:6 down to pin0 1:0.
// - legacy mode hides sense register; reset low-level.
// - I/O regs mirrored at plus 0x20; extended via data only.
// - edge sets pending; cleared on entry or write-one.
// - boot vector address equals table address plus boot start.
`ifndef EXT_IRQ_MAP_VH
`define EXT_IRQ_MAP_VH
`define CORE_CONTROL_IO 8'h35
`define IO_TO_DATA_OFFSET 8'h20
`define IO_SPACE_TOP 8'h3f
`define EXT_IO_BASE 8'h60
`define EXT_IRQ_SENSE_LOW_DATA 8'h6a
`define CORE_CONTROL_RESET 8'h00
`define EXT_IRQ_SENSE_LOW_RESET 8'h00
`define UNLOCK_BIT 0
`define SELECT_BIT 1
`define UNLOCK_CYCLES 3'd4
`define SENSE_LOW_LEVEL 2'b00
`define SENSE_RESERVED 2'b01
`define SENSE_FALLING 2'b10
`define SENSE_RISING 2'b11
`define SENSE_FIELD_WIDTH 2
`define LOWER_PIN_COUNT 4
`define WAKE_SAMPLES 2'd2
`endif

/* File: design/pin_sense.v */
`timescale 1ns/1ps
`include "ext_irq_map.vh"
module pin_sense (
    input wire clock,
    input wire rst_b,
    input wire clk_en,
    input wire sample_en,
    input wire pin_raw,
    input wire [1:0] sense,
    output wire level_low,
    output wire edge_hit
);
    reg sync_a;
    reg sync_b;
    reg prev;
    // two-stage synchronizer into the core clock domain
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sync_a <= 1'b1;
            sync_b <= 1'b1;
            prev <= 1'b1;
        end else if (clk_en) begin
            sync_a <= pin_raw;
            sync_b <= sync_a;
            if (sample_en) begin
                prev <= sync_b;
            end
        end
    end
    // pin sampled regardless of its port direction
    assign level_low = (sense == `SENSE_LOW_LEVEL) && !sync_b;
    // reserved code selects nothing
    assign edge_hit = sample_en && (
        ((sense == `SENSE_FALLING) && prev && !sync_b) ||
        ((sense == `SENSE_RISING) && !prev && sync_b));
endmodule

/* File: design/vector_change_ctl.v */
`timescale 1ns/1ps
`include "ext_irq_map.vh"
module vector_change_ctl (
    input wire clock,
    input wire rst_b,
    input wire clk_en,
    input wire ctl_wr,
    input wire [7:0] ctl_wdata,
    input wire instr_done,
    output reg vector_table_select,
    output reg vector_change_unlock,
    output wire change_block
);
    reg [2:0] unlock_left;
    reg after_write;
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            vector_table_select <= 1'b0;
            vector_change_unlock <= 1'b0;
            unlock_left <= 3'd0;
            after_write <= 1'b0;
        end else if (clk_en) begin
            if (ctl_wr && ctl_wdata[`UNLOCK_BIT]) begin
                vector_change_unlock <= 1'b1;
                unlock_left <= `UNLOCK_CYCLES - 3'd1;
            end else if (ctl_wr && vector_change_unlock) begin
                // select write inside the window
                vector_table_select <= ctl_wdata[`SELECT_BIT];
                vector_change_unlock <= 1'b0;
                unlock_left <= 3'd0;
                after_write <= 1'b1;
            end else if (vector_change_unlock) begin
                if (unlock_left == 3'd0) begin
                    vector_change_unlock <= 1'b0;
                end else begin
                    unlock_left <= unlock_left - 3'd1;
                end
            end
            // hold the block through the next instruction
            if (after_write && instr_done && !ctl_wr) begin
                after_write <= 1'b0;
            end
        end
    end
    // set unlock blocks in the cycle of its write
    assign change_block = vector_change_unlock || after_write ||
        (ctl_wr && ctl_wdata[`UNLOCK_BIT]);
endmodule

/* File: dv/ext_irq_chk_assertions.sv */
`timescale 1ns/1ps
module ext_irq_chk #(
    parameter PIN_COUNT = 4,
    parameter ADDR_WIDTH = 16
) (
    input wire clock,
    input wire rst_b,
    input wire clk_en,
    input wire [7:0] reg_addr,
    input wire reg_data_space,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire legacy_mode,
    input wire global_irq_enable,
    input wire [PIN_COUNT-1:0] ext_irq_mask_reg,
    input wire app_section_lock,
    input wire boot_section_lock,
    input wire running_in_boot,
    input wire [ADDR_WIDTH-1:0] boot_start_addr,
    input wire [ADDR_WIDTH-1:0] vector_offset,
    input wire [ADDR_WIDTH-1:0] vector_addr,
    input wire vector_table_select,
    input wire [PIN_COUNT-1:0] irq_request,
    input wire irq_blocked,
    input wire power_down,
    input wire wake_request
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    wire cc_wr = clk_en && reg_wr && !reg_data_space && reg_addr == 8'h35;
    wire lk = (app_section_lock && vector_table_select && !running_in_boot)
        || (boot_section_lock && !vector_table_select && running_in_boot);
    wire quiet = clk_en && !reg_wr && !lk;
    a_req_gated: assert property (|irq_request |-> global_irq_enable && !irq_blocked)
        else $error("request without enable or while blocked");
    a_req_masked: assert property ((irq_request & ~ext_irq_mask_reg) == {PIN_COUNT{1'b0}})
        else $error("request on masked pin");
    a_unlock_block: assert property (cc_wr && reg_wdata == 8'h01 |=> irq_blocked [*2])
        else $error("unlock did not block interrupts");
    a_block_four: assert property (cc_wr && reg_wdata == 8'h01 ##1 quiet [*3]
        |-> irq_blocked ##1 irq_blocked ##1 !irq_blocked)
        else $error("unlock window not four cycles");
    a_lock_block: assert property (lk |-> irq_blocked)
        else $error("section lock did not block");
    a_select_cause: assert property ($changed(vector_table_select) |-> $past(reg_wr && clk_en))
        else $error("select changed without write");
    a_vector_place: assert property ($past(rst_b) && $past(clk_en)
        && $stable(vector_table_select) |-> vector_addr == $past(vector_offset)
        + ($past(vector_table_select) ? $past(boot_start_addr) : {ADDR_WIDTH{1'b0}}))
        else $error("vector address wrong");
    a_rdata_hold: assert property (!(reg_rd && clk_en) |=> $stable(reg_rdata))
        else $error("read data moved without read");
    a_unmapped_zero: assert property (clk_en && reg_rd && reg_data_space
        && reg_addr == 8'h70 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_legacy_hide: assert property (clk_en && reg_rd && reg_data_space
        && reg_addr == 8'h6a && legacy_mode |=> reg_rdata == 8'h00)
        else $error("sense register visible in legacy mode");
    a_wake_hold: assert property (wake_request && power_down |=> wake_request)
        else $error("wake dropped during power down");
    a_wake_cause: assert property ($rose(wake_request) |-> $past(power_down))
        else $error("wake outside power down");
    cover property (cc_wr && reg_wdata == 8'h02);
    cover property ($rose(wake_request));
    cover property (|irq_request);
endmodule
bind ext_irq_and_vector_select ext_irq_chk #(.PIN_COUNT(PIN_COUNT), .ADDR_WIDTH(ADDR_WIDTH))
    ext_irq_chk_inst (.clock, .rst_b, .clk_en, .reg_addr, .reg_data_space, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .legacy_mode, .global_irq_enable, .ext_irq_mask_reg,
    .app_section_lock, .boot_section_lock, .running_in_boot, .boot_start_addr,
    .vector_offset, .vector_addr, .vector_table_select, .irq_request, .irq_blocked,
    .power_down, .wake_request);

/* File: dv/irq_source.sv */
`timescale 1ns/1ps
module irq_source #(
    parameter HOLD = 2
) (
    input wire clock,
    input wire [3:0] target,
    output reg [3:0] pins
);
    reg [2:0] hold;
    initial begin
        pins = 4'hf;
        hold = 3'h0;
    end
    // pins driven like outputs; they move just after the core edge, a new low held at least HOLD+1 cycles
    always @(posedge clock) begin
        if (|(~target & pins)) begin
            hold <= HOLD;
        end else if (hold != 3'h0) begin
            hold <= hold - 3'h1;
        end
        pins <= (hold != 3'h0) ? (pins & target) : target;
    end
endmodule

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    reg clock = 1'b0;
    reg rst_b = 1'b0;
    reg clk_en = 1'b1;
    reg [7:0] reg_addr = 8'h00;
    reg reg_data_space = 1'b0;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg [7:0] reg_wdata = 8'h00;
    reg legacy_mode = 1'b0;
    reg instr_done = 1'b0;
    reg global_irq_enable = 1'b0;
    reg [3:0] ext_irq_mask_reg = 4'h0;
    reg [3:0] flag_clear_wr = 4'h0;
    reg [3:0] irq_entered = 4'h0;
    reg [3:0] target = 4'hf;
    reg power_down = 1'b0;
    reg wdt_tick = 1'b0;
    reg app_section_lock = 1'b0;
    reg boot_section_lock = 1'b0;
    reg startup_done = 1'b0;
    reg running_in_boot = 1'b0;
    reg [15:0] boot_start_addr = 16'hf000;
    reg [15:0] vector_offset = 16'h0002;
    wire [3:0] ext_irq_pins_all;
    wire [7:0] reg_rdata;
    wire [15:0] vector_addr;
    wire vector_table_select;
    wire [3:0] ext_irq_pending_flag;
    wire [3:0] irq_request;
    wire irq_blocked;
    wire wake_request;
    integer num_errors = 0;
    integer checks = 0;
    integer cycles = 0;
    always #5 clock = ~clock;
    irq_source irq_source_inst (.clock, .target, .pins(ext_irq_pins_all));
    ext_irq_and_vector_select ext_irq_and_vector_select_inst (.clock, .rst_b, .clk_en,
        .reg_addr, .reg_data_space, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .legacy_mode,
        .instr_done, .global_irq_enable, .ext_irq_mask_reg, .flag_clear_wr, .irq_entered,
        .ext_irq_sense_high(8'h00), .ext_irq_pins_all, .io_clk_running(1'b1), .power_down,
        .wdt_tick, .startup_done, .app_section_lock, .boot_section_lock,
        .running_in_boot, .boot_start_addr, .vector_offset, .vector_addr,
        .vector_table_select, .ext_irq_pending_flag, .irq_request, .irq_blocked,
        .wake_request);
    task wrap_up;
        begin
            $display("checks %0d num_errors %0d", checks, num_errors);
            if (num_errors == 0 && checks > 0) begin
                $display("TB: PASS");
            end else begin
                $display("TB: FAIL");
            end
            $finish;
        end
    endtask
    task chk(input string nm, input [15:0] seen, input [15:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("wrong value %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(negedge clock);
    endtask
    task wr(input sp, input [7:0] a, input [7:0] d);
        begin
            reg_data_space = sp;
            reg_addr = a;
            reg_wdata = d;
            reg_wr = 1'b1;
            cyc(1);
            reg_wr = 1'b0;
            cyc(1);
        end
    endtask
    task rdc(input sp, input [7:0] a, input [7:0] exp, input string nm);
        begin
            reg_data_space = sp;
            reg_addr = a;
            reg_rd = 1'b1;
            cyc(1);
            reg_rd = 1'b0;
            chk(nm, reg_rdata, exp);
            cyc(1);
        end
    endtask
    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            num_errors = num_errors + 1;
            wrap_up;
        end
    end
    initial begin
        cyc(6);
        rst_b = 1'b1;
        rdc(0, 8'h35, 8'h00, "core_control");
        rdc(1, 8'h55, 8'h00, "core_control_data");
        rdc(1, 8'h6a, 8'h00, "sense_low");
        rdc(1, 8'h70, 8'h00, "unmapped");
        chk("vector_addr", vector_addr, 16'h0002);
        wr(1, 8'h6a, 8'he4);
        rdc(1, 8'h6a, 8'he4, "sense_low");
        wr(0, 8'h6a, 8'h00);
        rdc(1, 8'h6a, 8'he4, "sense_io_alias");
        legacy_mode = 1'b1;
        wr(1, 8'h6a, 8'h00);
        rdc(1, 8'h6a, 8'h00, "sense_legacy");
        legacy_mode = 1'b0;
        rdc(1, 8'h6a, 8'he4, "sense_kept");
        clk_en = 1'b0;
        wr(1, 8'h6a, 8'h00);
        clk_en = 1'b1;
        rdc(1, 8'h6a, 8'he4, "sense_frozen");
        wr(0, 8'h35, 8'h02);
        chk("select_locked", vector_table_select, 1'b0);
        wr(0, 8'h35, 8'h01);
        chk("blocked", irq_blocked, 1'b1);
        wr(1, 8'h55, 8'h02);
        chk("select", vector_table_select, 1'b1);
        rdc(0, 8'h35, 8'h02, "unlock_cleared");
        instr_done = 1'b1;
        cyc(1);
        instr_done = 1'b0;
        cyc(1);
        chk("block_end", irq_blocked, 1'b0);
        chk("vector_boot", vector_addr, 16'hf002);
        wr(0, 8'h35, 8'h01);
        cyc(5);
        rdc(0, 8'h35, 8'h02, "unlock_expired");
        wr(0, 8'h35, 8'h00);
        chk("select_kept", vector_table_select, 1'b1);
        app_section_lock = 1'b1;
        cyc(1);
        chk("lock_app", irq_blocked, 1'b1);
        running_in_boot = 1'b1;
        cyc(1);
        chk("lock_boot", irq_blocked, 1'b0);
        app_section_lock = 1'b0;
        global_irq_enable = 1'b1;
        ext_irq_mask_reg = 4'hf;
        target = 4'h0;
        cyc(1);
        chk("flags_sync", ext_irq_pending_flag, 4'h0);
        cyc(4);
        chk("flags_fall", ext_irq_pending_flag, 4'h4);
        chk("req_low", irq_request, 4'h5);
        cyc(3);
        chk("req_hold", irq_request, 4'h5);
        target = 4'hf;
        cyc(5);
        chk("flags_rise", ext_irq_pending_flag, 4'hc);
        chk("req_edge", irq_request, 4'hc);
        ext_irq_mask_reg = 4'h4;
        cyc(1);
        chk("req_masked", irq_request, 4'h4);
        global_irq_enable = 1'b0;
        cyc(1);
        chk("req_global", irq_request, 4'h0);
        flag_clear_wr = 4'h4;
        irq_entered = 4'h8;
        cyc(1);
        flag_clear_wr = 4'h0;
        irq_entered = 4'h0;
        chk("flags_clr", ext_irq_pending_flag, 4'h0);
        ext_irq_mask_reg = 4'h1;
        power_down = 1'b1;
        target = 4'he;
        cyc(4);
        chk("wake_early", wake_request, 1'b0);
        wdt_tick = 1'b1;
        cyc(2);
        wdt_tick = 1'b0;
        cyc(3);
        chk("wake", wake_request, 1'b1);
        power_down = 1'b0;
        target = 4'hf;
        cyc(2);
        chk("wake_off", wake_request, 1'b0);
        power_down = 1'b1;
        target = 4'he;
        cyc(4);
        chk("wake_wait", wake_request, 1'b0);
        startup_done = 1'b1;
        cyc(1);
        startup_done = 1'b0;
        cyc(1);
        chk("wake_startup", wake_request, 1'b1);
        power_down = 1'b0;
        target = 4'hf;
        cyc(2);
        wr(0, 8'h35, 8'h01);
        wr(0, 8'h35, 8'h00);
        chk("select_back", vector_table_select, 1'b0);
        instr_done = 1'b1;
        cyc(1);
        instr_done = 1'b0;
        boot_section_lock = 1'b1;
        cyc(1);
        chk("lock_boot_side", irq_blocked, 1'b1);
        chk("vector_flash", vector_addr, 16'h0002);
        running_in_boot = 1'b0;
        cyc(1);
        chk("lock_app_side", irq_blocked, 1'b0);
        wrap_up;
    end
endmodule
